/* hdl/bsq_pkg.sv */
package bsq_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int PADDR_W = 8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [PADDR_W-1:0] OFF_RCFG = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_STAT = 8'h08;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [15:0] RCFG_RESET = 16'hbfcf;
  localparam logic [15:0] RCFG_WMASK = 16'hbfcf;
  localparam logic CTRL_RESET = 1'h1;
  localparam logic HOLD_OFF_RESET = 1'h1;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_ARRAY_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DELAY_BIT = 4;
  localparam int STAT_WORD_LSB = 8;

  // ----------------------------------------
  // burst codes and boundaries
  // ----------------------------------------
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [1:0] GROUP_LAST = 2'h3;
  localparam logic [3:0] ROW_LAST = 4'hf;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic read_mode_select;
    logic rsv14;
    logic [2:0] first_access_latency;
    logic hold_off_polarity;
    logic data_hold_select;
    logic hold_off_timing;
    logic burst_order_select;
    logic clock_edge_select;
    logic rsv5;
    logic rsv4;
    logic wrap_disable;
    logic [2:0] burst_length_code;
  } bsq_rcfg_t;

  typedef struct packed {
    logic link_clk;
    logic chip_enable_n;
    logic address_valid_n;
    logic write_en_n;
    logic [ADDR_W-1:0] addr;
  } bsq_link_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LAT = 3'b001,
    ST_DATA = 3'b010,
    ST_DELAY = 3'b011
  } bsq_state_t;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [4:0] burst_words(input logic [2:0] code);
    if (code == BL_4) return 5'h04;
    else if (code == BL_8) return 5'h08;
    else if (code == BL_16) return 5'h10;
    else return 5'h00;
  endfunction

  function automatic logic [3:0] wrap_mask(input logic [2:0] code);
    if (code == BL_4) return 4'h3;
    else if (code == BL_8) return 4'h7;
    else if (code == BL_16) return 4'hf;
    else return 4'h0;
  endfunction

  function automatic logic [2:0] row_delay(input logic [2:0] lat,
                                          input logic [1:0] s);
    logic [3:0] t;
    t = {1'h0, lat} + {2'h0, s} - {2'h0, GROUP_LAST} - 4'h1;
    if (t[3] || t == 4'h0) return 3'h1;
    else return t[2:0];
  endfunction

endpackage

/* hdl/bsq_addr_gen.sv */
`timescale 1ns/1ps
module bsq_addr_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic advance,
  input wire logic [bsq_pkg::ADDR_W-1:0] start_addr,
  input wire logic [2:0] length_code,
  input wire logic wrap_disable,
  // burst address
  output logic [bsq_pkg::ADDR_W-1:0] word_addr
);
  localparam logic [bsq_pkg::ADDR_W-1:0] ONE = 16'h0001;

  logic [bsq_pkg::ADDR_W-1:0] next_word_addr;
  logic [bsq_pkg::ADDR_W-1:0] inc;
  logic [3:0] mask;
  logic linear;

  // ----------------------------------------
  // address order
  // ----------------------------------------
  always_comb begin
    mask = bsq_pkg::wrap_mask(length_code);
    inc = word_addr + ONE;
    linear = wrap_disable || length_code == bsq_pkg::BL_CONT;
    next_word_addr = word_addr;
    if (load) begin
      next_word_addr = start_addr;
    end else if (advance) begin
      if (linear) begin
        next_word_addr = inc;
      end else begin
        next_word_addr = {word_addr[bsq_pkg::ADDR_W-1:4],
                          (word_addr[3:0] & ~mask) | (inc[3:0] & mask)};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_addr <= 16'h0000;
    end else begin
      word_addr <= next_word_addr;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wrap_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    advance && !load && !linear |=> (word_addr[3:0] & ~$past(mask)) ==
      ($past(word_addr[3:0]) & ~$past(mask)))
    else $error("wrapped burst left its group");

endmodule

/* hdl/bsq_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// - hold-off pin is active low when polarity bit is 0, high when 1
// - hold-off deasserted only while the bus word is ready and valid
// - synchronous array reads: hold-off follows data validity word by word
// - synchronous non-array reads keep hold-off asserted throughout
// - asynchronous read mode keeps hold-off asserted
// - hold-off asserted during writes; output enable has no effect
// - data-hold bit gives one- or two-clock data cycles
// - timing bit: hold-off during delay or one data cycle before
// - no boundary delay for 4-word aligned start in linear bursts
// - misaligned start: one delay at most, only on 16-word crossing
// - start on last word of group gives delay of latency minus one
// - codes 1,2,3 give 4,8,16 words; wrap in group or linear
// - continuous bursts increment linearly to end of space
// - latency code sets clocks from strobe release to first word
// - clock-edge bit picks rising or falling link clock edge
// - status, query, identifier reads are single words, never bursts
module bsq_sequencer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bsq_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link from the controller
  input wire bsq_pkg::bsq_link_t link,
  // hold-off pin
  output logic hold_off,
  output logic hold_off_oe,
  // array side
  output logic [bsq_pkg::ADDR_W-1:0] array_addr,
  output logic word_valid
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  bsq_pkg::bsq_rcfg_t rcfg;
  bsq_pkg::bsq_rcfg_t next_rcfg;
  logic array_mode;
  logic next_array_mode;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  bsq_pkg::bsq_state_t st;
  bsq_pkg::bsq_state_t next_st;
  logic [2:0] lat_cnt;
  logic [2:0] next_lat_cnt;
  logic hold_cnt;
  logic next_hold_cnt;
  logic [4:0] word_cnt;
  logic [4:0] next_word_cnt;
  logic delay_used;
  logic next_delay_used;
  logic armed;
  logic next_armed;
  logic single;
  logic next_single;
  logic clk_prev;
  logic [bsq_pkg::ADDR_W-1:0] start_addr;
  logic [bsq_pkg::ADDR_W-1:0] next_start_addr;
  logic next_hold_off;
  logic next_hold_off_oe;
  logic next_word_valid;

  logic tick;
  logic gen_load;
  logic gen_adv;
  logic linear;
  logic row_end_condition;
  logic last_word;
  logic early;
  logic valid;
  logic pol;
  logic read_async;
  logic [4:0] blen;
  logic [2:0] lat_less_one;

  assign pol = rcfg.hold_off_polarity;
  assign read_async = rcfg.read_mode_select;
  assign lat_less_one = rcfg.first_access_latency - 3'h1;

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  always_comb begin
    next_rcfg = rcfg;
    next_array_mode = array_mode;
    next_pready = psel && !penable;
    next_pslverr = 1'h0;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (paddr == bsq_pkg::OFF_RCFG) begin
        next_prdata[15:0] = rcfg;
      end else if (paddr == bsq_pkg::OFF_CTRL) begin
        next_prdata[bsq_pkg::CTRL_ARRAY_BIT] = array_mode;
      end else if (paddr == bsq_pkg::OFF_STAT) begin
        next_prdata[bsq_pkg::STAT_STATE_LSB +: 3] = st;
        next_prdata[bsq_pkg::STAT_DELAY_BIT] = delay_used;
        next_prdata[bsq_pkg::STAT_WORD_LSB +: 5] = word_cnt;
      end else begin
        next_pslverr = 1'h1;
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (paddr == bsq_pkg::OFF_RCFG) begin
        next_rcfg = pwdata[15:0] & bsq_pkg::RCFG_WMASK;
      end else if (paddr == bsq_pkg::OFF_CTRL) begin
        next_array_mode = pwdata[bsq_pkg::CTRL_ARRAY_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcfg <= bsq_pkg::RCFG_RESET;
      array_mode <= bsq_pkg::CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      rcfg <= next_rcfg;
      array_mode <= next_array_mode;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  always_comb begin
    tick = rcfg.clock_edge_select ? (link.link_clk && !clk_prev)
                                  : (!link.link_clk && clk_prev);
    blen = bsq_pkg::burst_words(rcfg.burst_length_code);
    linear = rcfg.wrap_disable ||
             rcfg.burst_length_code == bsq_pkg::BL_CONT;
    row_end_condition = linear && !delay_used &&
                        start_addr[1:0] != 2'h0 &&
                        array_addr[3:0] == bsq_pkg::ROW_LAST;
    last_word = single || (blen != 5'h00 && word_cnt == blen - 5'h01) ||
                (blen == 5'h00 && &array_addr);
    early = rcfg.hold_off_timing && st == bsq_pkg::ST_DATA &&
            row_end_condition && !last_word;
    next_st = st;
    next_lat_cnt = lat_cnt;
    next_hold_cnt = hold_cnt;
    next_word_cnt = word_cnt;
    next_delay_used = delay_used;
    next_armed = armed;
    next_single = single;
    next_start_addr = start_addr;
    gen_load = 1'h0;
    gen_adv = 1'h0;
    if (link.chip_enable_n) begin
      next_st = bsq_pkg::ST_IDLE;
      next_armed = 1'h0;
    end else if (tick) begin
      if (!link.address_valid_n) begin
        next_armed = 1'h1;
        next_start_addr = link.addr;
        next_st = bsq_pkg::ST_IDLE;
      end else if (armed) begin
        next_armed = 1'h0;
        if (link.write_en_n && !read_async) begin
          next_st = bsq_pkg::ST_LAT;
          next_lat_cnt = rcfg.first_access_latency;
          next_single = !array_mode;
          next_delay_used = 1'h0;
          next_word_cnt = 5'h00;
          gen_load = 1'h1;
        end
      end else begin
        case (st)
          bsq_pkg::ST_LAT, bsq_pkg::ST_DELAY: begin
            if (lat_cnt <= 3'h1) begin
              next_st = bsq_pkg::ST_DATA;
              next_hold_cnt = rcfg.data_hold_select;
            end else begin
              next_lat_cnt = lat_cnt - 3'h1;
            end
          end
          bsq_pkg::ST_DATA: begin
            if (hold_cnt) begin
              next_hold_cnt = 1'h0;
            end else if (last_word) begin
              next_st = bsq_pkg::ST_IDLE;
            end else begin
              gen_adv = 1'h1;
              next_word_cnt = word_cnt + 5'h01;
              next_hold_cnt = rcfg.data_hold_select;
              if (row_end_condition) begin
                next_st = bsq_pkg::ST_DELAY;
                next_delay_used = 1'h1;
                next_lat_cnt = bsq_pkg::row_delay(
                  rcfg.first_access_latency, start_addr[1:0]);
              end
            end
          end
          default: begin
            next_st = bsq_pkg::ST_IDLE;
          end
        endcase
      end
    end
    valid = st == bsq_pkg::ST_DATA && !single && array_mode &&
            !read_async && link.write_en_n && !early;
    next_hold_off = pol ? !valid : valid;
    next_hold_off_oe = !link.chip_enable_n;
    next_word_valid = st == bsq_pkg::ST_DATA;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= bsq_pkg::ST_IDLE;
      lat_cnt <= 3'h0;
      hold_cnt <= 1'h0;
      word_cnt <= 5'h00;
      delay_used <= 1'h0;
      armed <= 1'h0;
      single <= 1'h0;
      clk_prev <= 1'h0;
      start_addr <= 16'h0000;
      hold_off <= bsq_pkg::HOLD_OFF_RESET;
      hold_off_oe <= 1'h0;
      word_valid <= 1'h0;
    end else begin
      st <= next_st;
      lat_cnt <= next_lat_cnt;
      hold_cnt <= next_hold_cnt;
      word_cnt <= next_word_cnt;
      delay_used <= next_delay_used;
      armed <= next_armed;
      single <= next_single;
      clk_prev <= link.link_clk;
      start_addr <= next_start_addr;
      hold_off <= next_hold_off;
      hold_off_oe <= next_hold_off_oe;
      word_valid <= next_word_valid;
    end
  end

  // ----------------------------------------
  // address generator
  // ----------------------------------------
  bsq_addr_gen u_addr (
    .pclk(pclk),
    .presetn(presetn),
    .load(gen_load),
    .advance(gen_adv),
    .start_addr(start_addr),
    .length_code(rcfg.burst_length_code),
    .wrap_disable(rcfg.wrap_disable),
    .word_addr(array_addr)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence data_cycle_s;
    st == bsq_pkg::ST_DATA && !single && array_mode && !read_async &&
    link.write_en_n && !early;
  endsequence

  sequence delay_entry_s;
    st != bsq_pkg::ST_DELAY ##1 st == bsq_pkg::ST_DELAY;
  endsequence

  data_ready_a: assert property (
    data_cycle_s |=> hold_off == !$past(pol))
    else $error("hold-off not released on valid word");

  pol_level_a: assert property (
    !pol && !valid ##1 !pol |-> hold_off == 1'h0)
    else $error("active-low hold-off not driven low");

  async_hold_a: assert property (
    read_async && $stable(pol) |=> hold_off == $past(pol))
    else $error("hold-off released in async mode");

  write_hold_a: assert property (
    !link.write_en_n && $stable(pol) |=> hold_off == $past(pol))
    else $error("hold-off released during write");

  nonarr_hold_a: assert property (
    !array_mode && $stable(pol) |=> hold_off == $past(pol))
    else $error("hold-off released in non-array read");

  early_hold_a: assert property (
    early && $stable(pol) |=> hold_off == $past(pol))
    else $error("hold-off not asserted before delay");

  aligned_nodelay_a: assert property (
    st == bsq_pkg::ST_DELAY |-> start_addr[1:0] != 2'h0)
    else $error("delay inserted for aligned start");

  delay_once_a: assert property (
    delay_entry_s |-> $past(delay_used) == 1'h0 &&
      array_addr[3:0] == 4'h0)
    else $error("delay repeated or off row boundary");

  worst_delay_a: assert property (
    delay_entry_s ##0 start_addr[1:0] == bsq_pkg::GROUP_LAST
      |-> lat_cnt == lat_less_one)
    else $error("worst-case delay length wrong");

  two_clock_a: assert property (
    st == bsq_pkg::ST_DATA && tick && hold_cnt && !link.chip_enable_n
      && link.address_valid_n && !armed
      |=> st == bsq_pkg::ST_DATA && word_cnt == $past(word_cnt))
    else $error("word left bus before second clock");

  single_word_a: assert property (
    st == bsq_pkg::ST_DATA && single |-> word_cnt == 5'h00)
    else $error("non-array read served as burst");

endmodule

/* test/bsq_ctrl_model.sv */
`timescale 1ns/1ps
module bsq_ctrl_model (
  // clock
  input wire logic pclk,
  // link to the device
  output bsq_pkg::bsq_link_t link
);
  // ----------------
  // burst frames
  // ----------------
  initial begin
    link = '{1'b0, 1'b1, 1'b1, 1'b1, 16'h0000};
  end
  // clock idles low; hold-off pin is never consulted
  task automatic frame(input logic [15:0] a, input logic wr,
                       input int ticks, input int hp);
    @(posedge pclk);
    link.chip_enable_n <= 1'b0;
    link.address_valid_n <= 1'b0;
    link.write_en_n <= ~wr;
    link.addr <= a;
    for (int i = 0; i < 2 * ticks; i++) begin
      repeat (hp) @(posedge pclk);
      link.link_clk <= ~link.link_clk;
      if (i == 1) begin
        repeat (hp / 2) @(posedge pclk);
        link.address_valid_n <= 1'b1;
        link.addr <= ~a;
      end
    end
    repeat (hp) @(posedge pclk);
    link.chip_enable_n <= 1'b1;
    link.write_en_n <= 1'b1;
  endtask
endmodule

/* test/bsq_sequencer_tb.sv */
`timescale 1ns/1ps
module bsq_sequencer_tb;
  // ----------------
  // signals
  // ----------------
  localparam logic [31:0] ZW = 32'h0000_0000;
  logic pclk, pready, pslverr, hold_off, hold_off_oe, word_valid, err;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [bsq_pkg::PADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = ZW;
  logic [31:0] prdata, rd;
  bsq_pkg::bsq_link_t link;
  logic [bsq_pkg::ADDR_W-1:0] array_addr;
  logic pol = 1'b1;
  logic edge_sel = 1'b1;
  logic mon_on = 1'b0;
  logic lc_q = 1'b0;
  logic wv_q = 1'b0;
  logic ce_q = 1'b1;
  logic [15:0] aa_q = 16'h0000;
  int fail_count = 0;
  int cmp_count = 0;
  int tick_n = 0;
  int first_tick = 0;
  int fall_tick = 0;
  int gap = 0;
  int early_ho = 0;
  int free_ho = 0;
  logic [15:0] seen[$];

  bsq_sequencer u_bsq_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link),
    .hold_off(hold_off), .hold_off_oe(hold_off_oe),
    .array_addr(array_addr), .word_valid(word_valid)
  );
  bsq_ctrl_model u_bsq_ctrl_model (.pclk(pclk), .link(link));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] cf(input logic rm, input logic [2:0] lt,
      input logic p, input logic h, input logic t, input logic e,
      input logic wd, input logic [2:0] bl);
    return {16'h0000, rm, 1'b0, lt, p, h, t, 1'b1, e, 2'b00, wd, bl};
  endfunction

  function automatic logic [15:0] xa(input logic [15:0] st,
      input logic [2:0] bl, input logic wd, input int i);
    logic [15:0] m;
    m = (bl == 3'h1) ? 16'h0003 : (bl == 3'h2) ? 16'h0007 : 16'h000f;
    if (wd || bl == bsq_pkg::BL_CONT) return st + 16'(i);
    return (st & ~m) | ((st + 16'(i)) & m);
  endfunction

  // link tick, word and hold-off watcher
  always @(posedge pclk) begin
    lc_q <= link.link_clk;
    wv_q <= word_valid;
    ce_q <= link.chip_enable_n;
    aa_q <= array_addr;
    if (link.chip_enable_n) tick_n <= 0;
    else if (link.link_clk !== lc_q && link.link_clk === edge_sel)
      tick_n <= tick_n + 1;
    if (word_valid === 1'b1 && wv_q !== 1'b1) begin
      if (seen.size() == 0) first_tick <= tick_n;
      else gap <= gap + tick_n - fall_tick;
    end
    if (word_valid === 1'b0 && wv_q === 1'b1) fall_tick <= tick_n;
    if (word_valid === 1'b1 && (wv_q !== 1'b1 || aa_q !== seen[$]))
      seen.push_back(aa_q);
    if (mon_on && hold_off !== pol) begin
      free_ho <= free_ho + 1;
      if (word_valid !== 1'b1) chk({31'h0, word_valid}, 32'h0000_0001);
    end
    if (hold_off === pol && word_valid === 1'b1) early_ho <= early_ho + 1;
    if (presetn) chk({31'h0, hold_off_oe}, {31'h0, !ce_q});
  end

  task automatic rb(input logic [31:0] c, input logic arr,
      input logic [15:0] st, input logic wr, input int nw, input int d,
      input int hp);
    int lt, h;
    lt = int'(c[13:11]);
    h = c[9] ? 2 : 1;
    mon_on = 1'b0;
    apb(1'b1, bsq_pkg::OFF_RCFG, c);
    apb(1'b1, bsq_pkg::OFF_CTRL, {31'h0, arr});
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    pol = c[10];
    edge_sel = c[6];
    seen.delete();
    gap = 0;
    early_ho = 0;
    free_ho = 0;
    mon_on = 1'b1;
    u_bsq_ctrl_model.frame(st, wr, 4 + lt + nw * h + d, hp);
    repeat (4) @(posedge pclk);
    if (!arr || wr || c[15]) begin
      chk(32'(free_ho), ZW);
      return;
    end
    chk(32'(first_tick), 32'(2 + lt));
    chk(32'(gap), 32'(d));
    chk(32'(early_ho > 0), 32'(c[8] && d > 0));
    chk(32'(free_ho > 0), 32'h0000_0001);
    if (c[2:0] != bsq_pkg::BL_CONT) begin
      chk(32'(seen.size()), 32'(nw));
      chk(32'(fall_tick - first_tick - gap), 32'(nw * h));
    end
    for (int i = 0; i < nw; i++) begin
      chk({16'h0000, seen[i]}, {16'h0000, xa(st, c[2:0], c[3], i)});
    end
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs;
    apb(1'b0, bsq_pkg::OFF_RCFG, ZW);
    chk(rd, {16'h0000, bsq_pkg::RCFG_RESET});
    apb(1'b0, bsq_pkg::OFF_CTRL, ZW);
    chk(rd, 32'h0000_0001);
    apb(1'b1, bsq_pkg::OFF_RCFG, 32'hffff_ffff);
    apb(1'b0, bsq_pkg::OFF_RCFG, ZW);
    chk(rd, {16'h0000, bsq_pkg::RCFG_WMASK});
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h0c, ZW);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("test regs done");
  endtask

  task automatic t_wrap;
    logic [15:0] st[3];
    st = '{16'h0123, 16'h0126, 16'h012e};
    for (int k = 0; k < 3; k++) begin
      rb(cf(1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'(k + 1)),
         1'b1, st[k], 1'b0, 4 << k, 0, 4);
    end
    $display("test wrap done");
  endtask

  // two-clock hold, falling edge, slow link clock
  task automatic t_linear;
    logic [15:0] st[3];
    st = '{16'h0204, 16'h0208, 16'h0214};
    for (int k = 0; k < 3; k++) begin
      rb(cf(1'b0, 3'h4, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'(k + 1)),
         1'b1, st[k], 1'b0, 4 << k, 0, 6);
    end
    $display("test linear done");
  endtask

  task automatic t_row;
    rb(cf(1'b0, 3'h4, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, bsq_pkg::BL_16),
       1'b1, 16'h0307, 1'b0, 16, 3, 4);
    apb(1'b0, bsq_pkg::OFF_STAT, ZW);
    chk(rd, 32'h0000_0f10);
    rb(cf(1'b0, 3'h5, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, bsq_pkg::BL_CONT),
       1'b1, 16'h0405, 1'b0, 30, 2, 4);
    rb(cf(1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, bsq_pkg::BL_CONT),
       1'b1, 16'hfffc, 1'b0, 4, 0, 4);
    chk(32'(seen.size()), 32'h0000_0004);
    $display("test row done");
  endtask

  task automatic t_modes;
    rb(cf(1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, bsq_pkg::BL_16),
       1'b0, 16'h0500, 1'b0, 16, 0, 4);
    chk(32'(seen.size()), 32'h0000_0001);
    rb(cf(1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, bsq_pkg::BL_4),
       1'b1, 16'h0600, 1'b0, 4, 0, 4);
    rb(cf(1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, bsq_pkg::BL_4),
       1'b1, 16'h0700, 1'b1, 4, 0, 4);
    $display("test modes done");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wrap();
    t_linear();
    t_row();
    t_modes();
    report_and_stop();
  end

  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
